// ===== hdl/ehp_port.sv
`timescale 1ns/1ps
// Contract
// R01: byte program: command 11b/10b, data on port 0, 16-bit address on address pins.
// R02: row burst program: command 01b/10b, bytes written one after another within a row.
// R03: verify: command 11b/00b drives addressed flash byte out on port 0.
// R04: commands other than chip erase aimed at a locked block are ignored.
// R05: three lock-bit commands set lock bits; only chip erase clears them.
// R06: remap-default commands set nonvolatile bits; working remap loaded from them after reset.
// R07: software writes to working remap bits never touch the nonvolatile defaults.
// R08: oscillator runs from entry-pin fall with reset high until host mode ends.
// R09: CPU core held in reset throughout host mode.
// R10: signature read held 1 ms arms the port; before that other commands ignored.
// R11: host keeps reset high, enters, arms, checks erased, strobes, waits ready.
// R12: ready/busy goes low after strobe fall, high when the operation completes.
// R13: ready rises after each burst byte; host sends next byte in page before timeout.
// R14: burst byte arriving after timeout is kept and programmed in a new cycle.
// R15: verify while programming returns complemented last byte on bits 7 and 3, others zero.
// R16: in a burst bit 7 true after each byte, bit 3 true only after termination.
// R17: burst ends on new row, another strobed command, or 20 us without a byte.
// R18: chip erase clears both blocks regardless of locks, and clears lock bits.
// R19: signature read returns the identification byte for the address on the pins.
// R20: operations start on strobe fall; host mode starts on entry-pin fall.
// R21: signature read selected by all four command pins low.
// R22: address from port 1, port 2 low six, port 3 pins 5 and 4.
// R23: every erase leaves affected bytes at FFh.
// R24: undefined command codes do nothing.
// R25: strobe and command pins synchronised first; each strobe fall launches one operation.
module ehp_port
  import ehp_pkg::*;
#(
  parameter int ARM_CYCLES = ARM_HOLD_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic rstPin,
  input wire logic hostModeEntryPin_n,
  input wire logic commandStrobePin_n,
  input wire logic externalAccessPin_n,
  input wire logic [7:0] port0In,
  input wire logic [7:0] port1In,
  input wire logic [7:0] port2In,
  input wire logic [7:0] port3In,
  output logic [7:0] port0Out,
  output logic port0Oe_n,
  output logic readyBusyPin,
  output logic cpuResetHold,
  output logic oscEnable,
  output logic [1:0] mapEnable,
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [3:0] avsByteEnable,
  input wire logic [31:0] avsWriteData,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest
);

  function automatic logic addrValid(input logic [15:0] a);
    return (~a[15]) | (a[15:12] == BLK1_TAG);
  endfunction

  function automatic logic [15:0] memIndex(input logic [15:0] a);
    return a[15] ? (BLK1_BASE | {4'h0, a[11:0]}) : {1'b0, a[14:0]};
  endfunction

  // half-sector row: 64 bytes in block 0, 32 bytes in block 1
  function automatic logic [10:0] rowOf(input logic [15:0] a);
    return a[15] ? a[15:5] : {1'b0, a[15:6]};
  endfunction

  // flash cells start erased, nonvolatile bits start clear
  logic [7:0] flashMem [0:MEM_DEPTH-1] = '{default: ERASED_BYTE};
  logic [2:0] lockBits = 3'h0;
  logic [1:0] remapDefault = 2'h0;

  ehp_pins_t pinsIn;
  ehp_pins_t pinsMeta;
  ehp_pins_t pinsSync;
  logic strobePrev;
  logic entryPrev;
  logic hostMode;
  logic hostModePrev;
  logic armed;
  logic [ARM_W-1:0] armCount;
  ehp_state_t state;
  logic [TIMER_W-1:0] opTimer;
  logic [TIMER_W-1:0] gapTimer;
  logic [15:0] workIdx;
  logic [15:0] eraseLast;
  logic eraseClearsNv;
  logic [10:0] burstRow;
  logic burstMode;
  logic burstOpen;
  logic [7:0] lastData;
  logic [3:0] nvCmd;
  logic loadMap;
  logic busAck;

  logic [3:0] cmdNow;
  logic [15:0] addrNow;
  logic [7:0] dataNow;
  logic strobeFall;
  logic blockLocked;
  logic launchProg;
  logic launchErase;
  logic launchNv;
  logic [15:0] launchLo;
  logic [15:0] launchHi;
  logic burstNext;
  logic opDone;
  logic eraseStep;
  logic nvSet;
  logic chipClear;
  logic busWriteCtrl;

  assign pinsIn = '{rstPin, hostModeEntryPin_n, commandStrobePin_n, externalAccessPin_n,
                    port0In, port1In, port2In, port3In};

  // two-stage synchroniser for every host pin
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pinsMeta <= '{1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 8'h00, 8'h00, 8'h00};
      pinsSync <= '{1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 8'h00, 8'h00, 8'h00};
      strobePrev <= 1'b1;
      entryPrev <= 1'b1;
    end else begin
      pinsMeta <= pinsIn; // R25
      pinsSync <= pinsMeta; // R25
      strobePrev <= pinsSync.commandStrobePin_n;
      entryPrev <= pinsSync.hostModeEntryPin_n;
    end
  end

  assign cmdNow = {pinsSync.port3[7:6], pinsSync.port2[7:6]};
  assign addrNow = {pinsSync.port3[5:4], pinsSync.port2[5:0], pinsSync.port1}; // R22
  assign dataNow = pinsSync.port0;
  assign strobeFall = strobePrev & ~pinsSync.commandStrobePin_n; // R25

  assign blockLocked = lockBits[2] | (~addrNow[15] & lockBits[0]) | ((addrNow[15:12] == BLK1_TAG) & lockBits[1]);

  // host mode entry and exit
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hostMode <= 1'b0;
      hostModePrev <= 1'b0;
    end else begin
      hostModePrev <= hostMode;
      if (!hostMode && entryPrev && !pinsSync.hostModeEntryPin_n && pinsSync.rstPin) begin
        hostMode <= 1'b1; // R20
      end else if (hostMode && (pinsSync.hostModeEntryPin_n || !pinsSync.rstPin)) begin
        hostMode <= 1'b0;
      end
    end
  end

  assign oscEnable = hostMode; // R08
  assign cpuResetHold = hostMode; // R09

  // arming: signature read held with strobe high for the hold time
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      armed <= 1'b0;
      armCount <= '0;
    end else if (!hostMode) begin
      armed <= 1'b0;
      armCount <= '0;
    end else if (!armed && cmdNow == CMD_SIG_READ && pinsSync.commandStrobePin_n) begin
      if (armCount == ARM_W'(ARM_CYCLES - 1)) begin
        armed <= 1'b1; // R10
      end else begin
        armCount <= armCount + 1'b1;
      end
    end else begin
      armCount <= '0;
    end
  end

  // decode of a strobed command against current pin state
  always_comb begin
    launchProg = 1'b0;
    launchErase = 1'b0;
    launchNv = 1'b0;
    launchLo = '0;
    launchHi = '0;
    if (hostMode && armed && strobeFall) begin // R10 R20
      unique case (cmdNow)
        CMD_CHIP_ERASE: begin
          launchErase = 1'b1; // R18
          launchHi = MEM_LAST;
        end
        CMD_BLOCK_ERASE: begin
          if (!blockLocked && !addrNow[15]) begin // R04
            launchErase = 1'b1;
            launchHi = BLK0_LAST;
          end else if (!blockLocked && addrNow[15:12] == BLK1_TAG) begin
            launchErase = 1'b1;
            launchLo = BLK1_BASE;
            launchHi = BLK1_LAST;
          end
        end
        CMD_SECTOR_ERASE: begin
          if (!blockLocked && addrValid(addrNow)) begin // R04
            launchErase = 1'b1;
            launchLo = addrNow[15] ? (memIndex(addrNow) & ~SECT1_SPAN) : (memIndex(addrNow) & ~SECT0_SPAN);
            launchHi = launchLo | (addrNow[15] ? SECT1_SPAN : SECT0_SPAN);
          end
        end
        CMD_BYTE_PROG, CMD_BURST_PROG: begin
          launchProg = !blockLocked && addrValid(addrNow); // R01 R02 R04
        end
        CMD_LOCK_ONE, CMD_LOCK_TWO, CMD_LOCK_THREE, CMD_REMAP_LOW, CMD_REMAP_HIGH: begin
          launchNv = 1'b1; // R05 R06
        end
        default: begin
          launchProg = 1'b0; // R24
        end
      endcase
    end
  end

  assign burstNext = launchProg && cmdNow == CMD_BURST_PROG && rowOf(addrNow) == burstRow;
  assign opDone = opTimer == '0;
  assign eraseStep = state == ST_ERASE;
  assign nvSet = state == ST_NVBIT && opDone;
  assign chipClear = eraseStep && eraseClearsNv && workIdx == eraseLast;

  // operation sequencer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      opTimer <= '0;
      gapTimer <= '0;
      workIdx <= '0;
      eraseLast <= '0;
      eraseClearsNv <= 1'b0;
      burstRow <= '0;
      burstMode <= 1'b0;
      burstOpen <= 1'b0;
      lastData <= ERASED_BYTE;
      nvCmd <= CMD_SIG_READ;
    end else begin
      unique case (state)
        ST_IDLE, ST_GAP: begin
          if (state == ST_GAP && burstNext) begin
            state <= ST_PROG; // R13
            opTimer <= TIMER_W'(PROG_TIME_CYCLES - 1);
            workIdx <= memIndex(addrNow);
            lastData <= dataNow;
          end else if (launchProg) begin
            state <= ST_PROG; // R01 R02 R14 R17
            opTimer <= TIMER_W'(PROG_TIME_CYCLES - 1);
            workIdx <= memIndex(addrNow);
            lastData <= dataNow;
            burstMode <= cmdNow == CMD_BURST_PROG;
            burstOpen <= cmdNow == CMD_BURST_PROG;
            burstRow <= rowOf(addrNow);
          end else if (launchErase) begin
            state <= ST_ERASE; // R17
            workIdx <= launchLo;
            eraseLast <= launchHi;
            eraseClearsNv <= cmdNow == CMD_CHIP_ERASE;
            burstOpen <= 1'b0;
            lastData <= ERASED_BYTE;
          end else if (launchNv) begin
            state <= ST_NVBIT; // R17
            opTimer <= TIMER_W'(PROG_TIME_CYCLES - 1);
            nvCmd <= cmdNow;
            burstOpen <= 1'b0;
          end else if (state == ST_GAP) begin
            if (strobeFall || gapTimer == '0) begin
              state <= ST_IDLE; // R17
              burstOpen <= 1'b0; // R16
            end else begin
              gapTimer <= gapTimer - 1'b1;
            end
          end
        end
        ST_PROG: begin
          if (opDone) begin
            state <= burstMode ? ST_GAP : ST_IDLE; // R13
            gapTimer <= TIMER_W'(BURST_TIMEOUT_CYCLES - 1);
          end else begin
            opTimer <= opTimer - 1'b1;
          end
        end
        ST_ERASE: begin
          if (workIdx == eraseLast) begin
            state <= ST_IDLE;
          end else begin
            workIdx <= workIdx + 1'b1;
          end
        end
        ST_NVBIT: begin
          if (opDone) begin
            state <= ST_IDLE;
          end else begin
            opTimer <= opTimer - 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // flash array: programming only clears bits
  always_ff @(posedge mclk) begin
    if (state == ST_PROG && opDone) begin
      flashMem[workIdx] <= flashMem[workIdx] & lastData; // R01 R02
    end else if (eraseStep) begin
      flashMem[workIdx] <= ERASED_BYTE; // R23
    end
  end

  // nonvolatile lock and remap-default bits, untouched by reset
  always_ff @(posedge mclk) begin
    if (chipClear) begin
      lockBits <= 3'h0; // R05 R18
      remapDefault <= 2'h0;
    end else if (nvSet) begin
      unique case (nvCmd)
        CMD_LOCK_ONE: lockBits[0] <= 1'b1; // R05
        CMD_LOCK_TWO: lockBits[1] <= 1'b1; // R05
        CMD_LOCK_THREE: lockBits[2] <= 1'b1; // R05
        CMD_REMAP_LOW: remapDefault[0] <= 1'b1; // R06
        CMD_REMAP_HIGH: remapDefault[1] <= 1'b1; // R06
        default: lockBits <= lockBits; // R24
      endcase
    end
  end

  // ready/busy pin and data port
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      readyBusyPin <= 1'b1;
      port0Out <= 8'h00;
      port0Oe_n <= 1'b1;
    end else begin
      readyBusyPin <= state == ST_IDLE || state == ST_GAP; // R12 R13
      port0Out <= 8'h00;
      port0Oe_n <= 1'b1;
      if (hostMode && pinsSync.commandStrobePin_n) begin
        if (cmdNow == CMD_SIG_READ) begin
          port0Oe_n <= 1'b0; // R19 R21
          if (addrNow[7:0] == SIG_MAKER_ADDR) begin
            port0Out <= SIG_MAKER_CODE;
          end else if (addrNow[7:0] == SIG_PART_ADDR) begin
            port0Out <= SIG_PART_CODE;
          end else begin
            port0Out <= ERASED_BYTE;
          end
        end else if (cmdNow == CMD_VERIFY && armed) begin
          if (state == ST_PROG || state == ST_ERASE) begin
            port0Oe_n <= 1'b0; // R15
            port0Out <= {~lastData[7], 3'h0, ~lastData[3], 3'h0};
          end else if (state == ST_GAP) begin
            port0Oe_n <= 1'b0; // R16
            port0Out <= {lastData[7], 3'h0, ~lastData[3], 3'h0};
          end else if (!blockLocked && addrValid(addrNow)) begin
            port0Oe_n <= 1'b0; // R03 R04
            port0Out <= flashMem[memIndex(addrNow)];
          end
        end
      end
    end
  end

  // working remap bits: loaded after reset and after host mode
  assign busWriteCtrl = avsWrite && busAck && avsAddress == REG_CTRL && avsByteEnable[0];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      loadMap <= 1'b1;
      mapEnable <= MAP_RESET;
    end else begin
      loadMap <= hostModePrev && !hostMode;
      if (loadMap) begin
        mapEnable <= remapDefault; // R06
      end else if (busWriteCtrl) begin
        mapEnable <= avsWriteData[1:0]; // R07
      end
    end
  end

  // register slave: one wait cycle per access
  assign avsWaitRequest = (avsRead || avsWrite) && !busAck;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busAck <= 1'b0;
      avsReadData <= 32'h0000_0000;
    end else begin
      busAck <= (avsRead || avsWrite) && !busAck;
      if (avsRead && !busAck) begin
        unique case (avsAddress)
          REG_CTRL: avsReadData <= {30'h0000_0000, mapEnable};
          REG_STATUS: avsReadData <= {21'h00_0000, mapEnable, remapDefault, lockBits, burstOpen,
                                      !readyBusyPin, armed, hostMode};
          default: avsReadData <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ===== hdl/ehp_pkg.sv
package ehp_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int ARM_HOLD_US = 1;
  localparam int ARM_HOLD_NS = ARM_HOLD_US * 1000;
  localparam int ARM_HOLD_CYCLES = (ARM_HOLD_NS * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BURST_TIMEOUT_US = 20;
  localparam int BURST_TIMEOUT_CYCLES = (BURST_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int PROG_TIME_US = 10;
  localparam int PROG_TIME_CYCLES = (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 12;
  localparam int ARM_W = 16;

  // command codes {port3[7:6], port2[7:6]}
  localparam logic [3:0] CMD_SIG_READ = 4'h0;
  localparam logic [3:0] CMD_CHIP_ERASE = 4'h1;
  localparam logic [3:0] CMD_BLOCK_ERASE = 4'hD;
  localparam logic [3:0] CMD_SECTOR_ERASE = 4'hB;
  localparam logic [3:0] CMD_BYTE_PROG = 4'hE;
  localparam logic [3:0] CMD_BURST_PROG = 4'h6;
  localparam logic [3:0] CMD_VERIFY = 4'hC;
  localparam logic [3:0] CMD_LOCK_ONE = 4'hF;
  localparam logic [3:0] CMD_LOCK_TWO = 4'h3;
  localparam logic [3:0] CMD_LOCK_THREE = 4'h5;
  localparam logic [3:0] CMD_REMAP_LOW = 4'h8;
  localparam logic [3:0] CMD_REMAP_HIGH = 4'h9;

  // memory layout: block 0 at 0000..7FFF, block 1 at F000..FFFF
  localparam int MEM_DEPTH = 36864;
  localparam logic [15:0] BLK1_BASE = 16'h8000;
  localparam logic [15:0] BLK0_LAST = 16'h7FFF;
  localparam logic [15:0] BLK1_LAST = 16'h8FFF;
  localparam logic [15:0] MEM_LAST = 16'h8FFF;
  localparam logic [15:0] SECT0_SPAN = 16'h007F;
  localparam logic [15:0] SECT1_SPAN = 16'h003F;
  localparam logic [3:0] BLK1_TAG = 4'hF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // signature locations; code values are arbitrary
  localparam logic [7:0] SIG_MAKER_ADDR = 8'h30;
  localparam logic [7:0] SIG_PART_ADDR = 8'h31;
  localparam logic [7:0] SIG_MAKER_CODE = 8'h5A;
  localparam logic [7:0] SIG_PART_CODE = 8'h3C;

  // register byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [1:0] MAP_RESET = 2'h0;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PROG = 5'b00010,
    ST_GAP = 5'b00100,
    ST_ERASE = 5'b01000,
    ST_NVBIT = 5'b10000
  } ehp_state_t;

  typedef struct packed {
    logic rstPin;
    logic hostModeEntryPin_n;
    logic commandStrobePin_n;
    logic externalAccessPin_n;
    logic [7:0] port0;
    logic [7:0] port1;
    logic [7:0] port2;
    logic [7:0] port3;
  } ehp_pins_t;

endpackage

// ===== tb/ehp_port_checker.sv
`timescale 1ns/1ps
module ehp_port_checker
  import ehp_pkg::*;
#(
  parameter int ARM_CYCLES = ARM_HOLD_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic rstPin,
  input wire logic hostModeEntryPin_n,
  input wire logic commandStrobePin_n,
  input wire logic externalAccessPin_n,
  input wire logic [7:0] port0In,
  input wire logic [7:0] port1In,
  input wire logic [7:0] port2In,
  input wire logic [7:0] port3In,
  input wire logic [7:0] port0Out,
  input wire logic port0Oe_n,
  input wire logic readyBusyPin,
  input wire logic cpuResetHold,
  input wire logic oscEnable,
  input wire logic [1:0] mapEnable,
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [3:0] avsByteEnable,
  input wire logic [31:0] avsWriteData,
  input wire logic [31:0] avsReadData,
  input wire logic avsWaitRequest
);
  logic strobeQ;
  logic readyQ;
  logic [1:0] fallsSince;
  logic [3:0] sinceStrobe;
  logic [15:0] busyCount;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) sinceStrobe <= 4'hF;
    else if (!commandStrobePin_n) sinceStrobe <= 4'h0;
    else if (sinceStrobe != 4'hF) sinceStrobe <= sinceStrobe + 4'h1;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) busyCount <= 16'h0000;
    else if (readyBusyPin) busyCount <= 16'h0000;
    else if (busyCount != 16'hFFFF) busyCount <= busyCount + 16'h0001;
  end

  // operations started since the last strobe fall
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      strobeQ <= 1'b1;
      readyQ <= 1'b1;
      fallsSince <= 2'h0;
    end else begin
      strobeQ <= commandStrobePin_n;
      readyQ <= readyBusyPin;
      if (strobeQ && !commandStrobePin_n) fallsSince <= 2'h0;
      else if (readyQ && !readyBusyPin && fallsSince != 2'h3) fallsSince <= fallsSince + 2'h1;
    end
  end

  AST_CPU_ON:
  assert property ($fell(hostModeEntryPin_n) && rstPin |-> ##[1:5] cpuResetHold) else $error("core not held");
  AST_OSC_ON:
  assert property ($fell(hostModeEntryPin_n) && rstPin |-> ##[1:5] oscEnable) else $error("oscillator not started");
  AST_OSC_OFF:
  assert property ($rose(hostModeEntryPin_n) |-> ##[1:5] !oscEnable) else $error("oscillator not stopped");
  AST_STROBE_CAUSE:
  assert property ($fell(readyBusyPin) |-> sinceStrobe <= 4'h8) else $error("busy without strobe");
  AST_BUSY_MIN:
  assert property ($fell(readyBusyPin) |-> (!readyBusyPin) [*8]) else $error("busy pulse too short");
  AST_BUSY_BOUND:
  assert property (busyCount <= 16'h9024) else $error("busy never ends");
  AST_ONE_OP:
  assert property (fallsSince <= 2'h1) else $error("two operations from one strobe");
  AST_IDLE_OUTSIDE:
  assert property (!cpuResetHold && !$past(cpuResetHold) |-> port0Oe_n && readyBusyPin)
    else $error("activity outside host mode");
  AST_POLL_FORM:
  assert property (!readyBusyPin && !$past(readyBusyPin) && !$past(readyBusyPin, 2) && !$past(port0Oe_n)
    |-> ($past(port0Out) & 8'h77) == 8'h00) else $error("polling byte has extra bits");
endmodule

bind ehp_port ehp_port_checker #(.ARM_CYCLES(ARM_CYCLES)) u_ehp_port_checker (
  .mclk(mclk), .reset_n(reset_n), .rstPin(rstPin), .hostModeEntryPin_n(hostModeEntryPin_n),
  .commandStrobePin_n(commandStrobePin_n), .externalAccessPin_n(externalAccessPin_n), .port0In(port0In),
  .port1In(port1In), .port2In(port2In), .port3In(port3In), .port0Out(port0Out), .port0Oe_n(port0Oe_n),
  .readyBusyPin(readyBusyPin), .cpuResetHold(cpuResetHold), .oscEnable(oscEnable), .mapEnable(mapEnable),
  .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsByteEnable(avsByteEnable),
  .avsWriteData(avsWriteData), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest));

// ===== tb/ehp_host_model.sv
`timescale 1ns/1ps
module ehp_host_model
  import ehp_pkg::*;
(
  input wire logic mclk,
  output ehp_pins_t pins
);
  initial begin
    pins = '0;
    pins.hostModeEntryPin_n = 1'b1;
    pins.commandStrobePin_n = 1'b1;
    pins.port3 = 8'hC0;
  end

  task automatic enter();
    @(posedge mclk);
    pins.rstPin <= 1'b1;
    pins.externalAccessPin_n <= 1'b1;
    repeat (4) @(posedge mclk);
    pins.hostModeEntryPin_n <= 1'b0;
  endtask

  task automatic leave();
    @(posedge mclk);
    pins.hostModeEntryPin_n <= 1'b1;
  endtask

  task automatic present(input logic [3:0] c, input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    pins.port3 <= {c[3:2], a[15:14], 4'h0};
    pins.port2 <= {c[1:0], a[13:8]};
    pins.port1 <= a[7:0];
    pins.port0 <= d;
  endtask

  // pins settle a cycle before the strobe falls; data is inverted on the same edge that it rises
  task automatic strobe(input logic [3:0] c, input logic [15:0] a, input logic [7:0] d);
    present(c, a, d);
    @(posedge mclk);
    pins.commandStrobePin_n <= 1'b0;
    repeat (4) @(posedge mclk);
    pins.commandStrobePin_n <= 1'b1;
    pins.port0 <= ~d;
  endtask
endmodule

// ===== tb/tb_ehp_port.sv
`timescale 1ns/1ps
module tb_ehp_port
  import ehp_pkg::*;
;
  localparam int ARM_SIM = 20;
  logic mclk;
  logic reset_n;
  ehp_pins_t pins;
  logic [7:0] port0Out;
  logic port0Oe_n;
  logic readyBusyPin;
  logic cpuResetHold;
  logic oscEnable;
  logic [1:0] mapEnable;
  logic [3:0] avsAddress;
  logic avsRead;
  logic avsWrite;
  logic [31:0] avsWriteData;
  logic [31:0] avsReadData;
  logic avsWaitRequest;
  logic [31:0] rdata;
  logic [3:0] lockCmd [3] = '{CMD_LOCK_ONE, CMD_LOCK_TWO, CMD_LOCK_THREE};
  logic [3:0] remapCmd [2] = '{CMD_REMAP_LOW, CMD_REMAP_HIGH};
  int fails;
  int comparisons;
  int cycles;

  ehp_host_model u_ehp_host_model (.mclk(mclk), .pins(pins));

  ehp_port #(.ARM_CYCLES(ARM_SIM)) u_ehp_port (
    .mclk(mclk), .reset_n(reset_n), .rstPin(pins.rstPin), .hostModeEntryPin_n(pins.hostModeEntryPin_n),
    .commandStrobePin_n(pins.commandStrobePin_n), .externalAccessPin_n(pins.externalAccessPin_n),
    .port0In(pins.port0), .port1In(pins.port1), .port2In(pins.port2), .port3In(pins.port3),
    .port0Out(port0Out), .port0Oe_n(port0Oe_n), .readyBusyPin(readyBusyPin), .cpuResetHold(cpuResetHold),
    .oscEnable(oscEnable), .mapEnable(mapEnable), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsByteEnable(4'hF), .avsWriteData(avsWriteData), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest));

  task automatic end_sim();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge mclk);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= ~wr;
    avsWriteData <= wd;
    do begin
      @(posedge mclk);
    end while (avsWaitRequest !== 1'b0);
    rdata = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] c, input logic [15:0] a, input logic oeN, input logic [7:0] d);
    u_ehp_host_model.present(c, a, 8'hFF);
    repeat (6) @(posedge mclk);
    check("port0Oe_n", port0Oe_n, oeN);
    if (!oeN) check("port0Out", port0Out, d);
  endtask

  task automatic waitOp(input int lim);
    int n;
    n = 0;
    while (readyBusyPin !== 1'b0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    check("busy", readyBusyPin, 1'b0);
    n = 0;
    while (readyBusyPin !== 1'b1 && n < lim) begin
      @(posedge mclk);
      n++;
    end
    check("ready", readyBusyPin, 1'b1);
  endtask

  task automatic noOp(input logic [3:0] c, input logic [15:0] a);
    logic low;
    low = 1'b0;
    u_ehp_host_model.strobe(c, a, 8'h00);
    repeat (20) begin
      @(posedge mclk);
      if (readyBusyPin !== 1'b1) low = 1'b1;
    end
    check("ignored", low, 1'b0);
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    cycles = 0;
    while (cycles < 60000) begin
      @(posedge mclk);
      cycles++;
    end
    fails++;
    end_sim();
  end

  initial begin
    reset_n = 1'b0;
    avsAddress = 4'h0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWriteData = 32'h0000_0000;
    fails = 0;
    comparisons = 0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    u_ehp_host_model.enter();
    repeat (8) @(posedge mclk);
    check("cpuResetHold", cpuResetHold, 1'b1);
    check("oscEnable", oscEnable, 1'b1);
    noOp(CMD_BYTE_PROG, 16'h0040);
    u_ehp_host_model.present(CMD_SIG_READ, {8'h00, SIG_MAKER_ADDR}, 8'hFF);
    repeat (ARM_SIM + 10) @(posedge mclk);
    rd(CMD_SIG_READ, {8'h00, SIG_MAKER_ADDR}, 1'b0, SIG_MAKER_CODE);
    rd(CMD_SIG_READ, {8'h00, SIG_PART_ADDR}, 1'b0, SIG_PART_CODE);
    rd(CMD_VERIFY, 16'h0040, 1'b0, ERASED_BYTE);
    u_ehp_host_model.strobe(CMD_BYTE_PROG, 16'h0010, 8'hA5);
    rd(CMD_VERIFY, 16'h0010, 1'b0, 8'h08);
    waitOp(400);
    rd(CMD_VERIFY, 16'h0010, 1'b0, 8'hA5);
    u_ehp_host_model.strobe(CMD_BURST_PROG, 16'h0080, 8'h11);
    waitOp(400);
    u_ehp_host_model.strobe(CMD_BURST_PROG, 16'h0081, 8'hA2);
    waitOp(400);
    u_ehp_host_model.present(CMD_VERIFY, 16'h0081, 8'hFF);
    repeat (6) @(posedge mclk);
    check("gapPoll", {24'h0, port0Out & 8'h88}, 32'h88);
    bus(1'b0, REG_STATUS, 32'h0);
    check("burstOpen", rdata[3], 1'b1);
    repeat (BURST_TIMEOUT_CYCLES + 50) @(posedge mclk);
    bus(1'b0, REG_STATUS, 32'h0);
    check("burstOpen", rdata[3], 1'b0);
    rd(CMD_VERIFY, 16'h0081, 1'b0, 8'hA2);
    rd(CMD_VERIFY, 16'h0080, 1'b0, 8'h11);
    u_ehp_host_model.strobe(CMD_BURST_PROG, 16'h0082, 8'h33);
    waitOp(400);
    u_ehp_host_model.strobe(CMD_BYTE_PROG, 16'h0083, 8'h44);
    waitOp(400);
    rd(CMD_VERIFY, 16'h0082, 1'b0, 8'h33);
    rd(CMD_VERIFY, 16'h0083, 1'b0, 8'h44);
    for (int i = 0; i < 3; i++) begin
      u_ehp_host_model.strobe(lockCmd[i], 16'h0000, 8'h00);
      waitOp(400);
      bus(1'b0, REG_STATUS, 32'h0);
      check("lockBits", rdata[6:4], (3'h2 << i) - 3'h1);
    end
    rd(CMD_VERIFY, 16'h0010, 1'b1, 8'h00);
    noOp(CMD_BYTE_PROG, 16'h0011);
    noOp(4'h2, 16'h0000);
    u_ehp_host_model.strobe(CMD_CHIP_ERASE, 16'h0000, 8'h00);
    waitOp(40000);
    bus(1'b0, REG_STATUS, 32'h0);
    check("lockBits", rdata[6:4], 3'h0);
    rd(CMD_VERIFY, 16'h0010, 1'b0, ERASED_BYTE);
    rd(CMD_VERIFY, 16'h0083, 1'b0, ERASED_BYTE);
    for (int i = 0; i < 2; i++) begin
      u_ehp_host_model.strobe(remapCmd[i], 16'h0000, 8'h00);
      waitOp(400);
      bus(1'b0, REG_STATUS, 32'h0);
      check("remapDefault", rdata[8:7], (2'h2 << i) - 2'h1);
    end
    u_ehp_host_model.leave();
    repeat (8) @(posedge mclk);
    check("oscEnable", oscEnable, 1'b0);
    check("cpuResetHold", cpuResetHold, 1'b0);
    bus(1'b1, REG_CTRL, 32'h0000_0002);
    bus(1'b0, REG_STATUS, 32'h0);
    check("remapDefault", rdata[8:7], 2'h3);
    check("mapEnable", mapEnable, 2'h2);
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    check("mapEnable", mapEnable, 2'h3);
    bus(1'b0, 4'h8, 32'h0);
    check("unmapped", rdata, 32'h0000_0000);
    end_sim();
  end
endmodule
